//--- flash_fe_defs.vh
// constants for the serial flash front end
`ifndef FLASH_FE_DEFS_VH
`define FLASH_FE_DEFS_VH
`define ADDR_W        24
`define ARRAY_TOP     24'h0FFFFF
`define SECTOR_LSB    12
`define HALF_LSB      15
`define BLOCK_LSB     16
`define SECTOR_W      8
`define HALF_W        5
`define BLOCK_W       4
`define BIT_CNT_W     3
`define BYTE_LAST     3'h7
`define BYTE_CNT_W    3
`define ADDR_BYTES    3'h3
`define CMD_WRITE_ENABLE_CMD      8'h06
`define CMD_WRDI      8'h04
`define CMD_RDSR      8'h05
`define CMD_STATUS_WRITE_CMD      8'h01
`define CMD_READ      8'h03
`define CMD_PP        8'h02
`define CMD_SE        8'h20
`define CMD_BE32      8'h52
`define CMD_BE        8'hD8
`define CMD_CE        8'h60
`define CMD_CE2       8'hC7
`define KIND_W        3
`define KIND_NONE     3'h0
`define KIND_WRITE_ENABLE_CMD     3'h1
`define KIND_WRDI     3'h2
`define KIND_RDSR     3'h3
`define KIND_READ     3'h4
`define KIND_MODIFY   3'h5
`endif

//--- flash_fe_buf.v
// two-entry valid/ready buffer for received words
`timescale 1ns/100ps
module flash_fe_buf #(
  parameter WIDTH = 8
) (
  input  wire             mclk,
  input  wire             reset,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:1];
  reg             wr_ptr_r;
  reg             rd_ptr_r;
  reg [1:0]       count_r;
  wire            push;
  wire            pop;

  assign in_ready  = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge mclk) begin
    if (reset) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (push & ~pop) begin
        count_r <= count_r + 2'h1;
      end else if (pop & ~push) begin
        count_r <= count_r - 2'h1;
      end
    end
  end

  always @(posedge mclk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule

//--- flash_fe.v
// device-side serial front end of a 1 MB serial flash
// How it works
// - addresses up to 0FFFFFh split into 4KB sectors, 32KB and 64KB blocks
// - unknown opcode drops to standby until next select fall, output floats
// - known opcode stays active until chip select rises
// - inputs sampled on clock rise, outputs changed on clock fall
// - clock may idle high or low; both work
// - read commands may end after any output bit
// - modifying commands execute only if select rises on a byte boundary
// - array access ignored while an internal operation runs
// - pause halts only serial traffic, internal work continues
// - pause begins on pause fall with clock low, else waits for clock low
// - pause ends on pause rise with clock low, else waits for clock low
// - output floats from pause fall until pause rise
// - input ignored while paused
// - select rise while paused resets the interface
// - pause disabled in four-wire mode
// - pause shares the fourth data pin; active low in single-wire modes
// - modifying commands need the write latch set first
`timescale 1ns/100ps
`include "flash_fe_defs.vh"

module flash_fe (
  input  wire                 mclk,
  input  wire                 reset,
  input  wire                 cs_n,
  input  wire                 sclk,
  input  wire                 si,
  output reg                  so,
  output wire                 so_oe,
  input  wire                 quad_data_3_i,
  output wire                 quad_data_3_o,
  output wire                 quad_data_3_oe,
  input  wire                 quad_mode,
  input  wire                 busy,
  input  wire [7:0]           status_in,
  input  wire [7:0]           array_rdata,
  output reg  [`ADDR_W-1:0]   addr_r,
  output reg                  array_rd_r,
  output reg  [`KIND_W-1:0]   exec_kind_r,
  output reg  [7:0]           exec_op_r,
  output reg                  exec_r,
  output reg                  write_latch_flag,
  output reg  [`SECTOR_W-1:0] sector_r,
  output reg  [`HALF_W-1:0]   half_block_r,
  output reg  [`BLOCK_W-1:0]  block_r,
  output reg                  addr_valid_r,
  output wire                 data_valid,
  input  wire                 data_ready,
  output wire [7:0]           data_out,
  output reg                  active_r,
  output reg                  paused_r
);

  localparam ST_IDLE  = 4'b0001;
  localparam ST_CMD   = 4'b0010;
  localparam ST_ACT   = 4'b0100;
  localparam ST_STBY  = 4'b1000;


  // two-flop synchronisers
  reg [1:0] cs_s_r, clk_s_r, si_s_r, hold_s_r;
  reg       clk_d_r, cs_d_r;
  always @(posedge mclk) begin
    if (reset) begin
      cs_s_r   <= 2'h3;
      clk_s_r  <= 2'h0;
      si_s_r   <= 2'h0;
      hold_s_r <= 2'h3;
      clk_d_r  <= 1'b0;
      cs_d_r   <= 1'b1;
    end else begin
      cs_s_r   <= {cs_s_r[0], cs_n};
      clk_s_r  <= {clk_s_r[0], sclk};
      si_s_r   <= {si_s_r[0], si};
      hold_s_r <= {hold_s_r[0], quad_data_3_i};
      clk_d_r  <= clk_s_r[1];
      cs_d_r   <= cs_s_r[1];
    end
  end

  wire csn   = cs_s_r[1];
  wire clk_v = clk_s_r[1];
  wire din   = si_s_r[1];
  wire hold  = hold_s_r[1];

  // either idle level works, only edges count
  wire rise  = clk_v & ~clk_d_r & ~csn & ~paused_r;
  wire fall  = ~clk_v & clk_d_r & ~csn & ~paused_r;
  wire cs_fall = ~csn & cs_d_r;
  wire cs_rise = csn & ~cs_d_r;

  function [`KIND_W-1:0] kind_of;
    input [7:0] op;
    begin
      if (op == `CMD_WRITE_ENABLE_CMD) kind_of = `KIND_WRITE_ENABLE_CMD;
      else if (op == `CMD_WRDI) kind_of = `KIND_WRDI;
      else if (op == `CMD_RDSR) kind_of = `KIND_RDSR;
      else if (op == `CMD_READ) kind_of = `KIND_READ;
      else if (op == `CMD_STATUS_WRITE_CMD || op == `CMD_PP || op == `CMD_SE ||
               op == `CMD_BE32 || op == `CMD_BE || op == `CMD_CE ||
               op == `CMD_CE2) kind_of = `KIND_MODIFY;
      else kind_of = `KIND_NONE;
    end
  endfunction

  function needs_addr;
    input [7:0] op;
    begin
      needs_addr = (op == `CMD_READ) || (op == `CMD_PP) ||
                   (op == `CMD_SE) || (op == `CMD_BE32) || (op == `CMD_BE);
    end
  endfunction

  // pause: entry and exit only with the clock low
  // internal work never looks at the pause state
  wire pause_en = ~quad_mode;
  always @(posedge mclk) begin
    if (reset) begin
      paused_r <= 1'b0;
    end else if (csn | ~pause_en) begin
      paused_r <= 1'b0;
    end else if (~paused_r & ~hold & ~clk_v) begin
      paused_r <= 1'b1;
    end else if (paused_r & hold & ~clk_v) begin
      paused_r <= 1'b0;
    end
  end

  reg [3:0]               state_r;
  reg [`BIT_CNT_W-1:0]    bit_r;
  reg [7:0]               sh_r;
  reg [7:0]               op_r;
  reg [`BYTE_CNT_W-1:0]   nbyte_r;
  reg [7:0]               out_sh_r;
  reg                     out_en_r;
  reg                     push_r;
  reg [7:0]               push_data_r;
  wire                    buf_ready;
  wire [7:0]              byte_nxt = {sh_r[6:0], din};
  wire                    byte_done = rise & (bit_r == `BYTE_LAST);
  wire [`KIND_W-1:0]      op_kind = kind_of(op_r);

  // accepted at select rise only on a byte boundary; modifying
  // commands also need the latch, an idle array and a full address
  wire                    on_boundary = (state_r == ST_ACT) &&
                                        (bit_r == {`BIT_CNT_W{1'b0}});
  wire                    latch_cmd = (op_kind == `KIND_WRITE_ENABLE_CMD) ||
                                      (op_kind == `KIND_WRDI);
  wire                    addr_done = ~needs_addr(op_r) ||
                                      (nbyte_r == `ADDR_BYTES + 3'h1);
  wire                    mod_ok = (op_kind == `KIND_MODIFY) &&
                                   write_latch_flag && ~busy && addr_done;
  wire                    accept = on_boundary & (latch_cmd | mod_ok);

  always @(posedge mclk) begin
    if (reset) begin
      state_r          <= ST_IDLE;
      bit_r            <= {`BIT_CNT_W{1'b0}};
      sh_r             <= 8'h00;
      op_r             <= 8'h00;
      nbyte_r          <= {`BYTE_CNT_W{1'b0}};
      addr_r           <= {`ADDR_W{1'b0}};
      array_rd_r       <= 1'b0;
      exec_kind_r      <= `KIND_NONE;
      exec_op_r        <= 8'h00;
      exec_r           <= 1'b0;
      write_latch_flag <= 1'b0;
      out_sh_r         <= 8'h00;
      out_en_r         <= 1'b0;
      so               <= 1'b0;
      push_r           <= 1'b0;
      push_data_r      <= 8'h00;
      active_r         <= 1'b0;
    end else begin
      exec_r     <= 1'b0;
      array_rd_r <= 1'b0;
      if (push_r & buf_ready) begin
        push_r <= 1'b0;
      end

      if (cs_rise) begin
        // modify class needs byte alignment and the latch
        if (accept) begin
          exec_r      <= 1'b1;
          exec_kind_r <= op_kind;
          exec_op_r   <= op_r;
          if (op_kind == `KIND_WRITE_ENABLE_CMD) write_latch_flag <= 1'b1;
          if (op_kind == `KIND_WRDI) write_latch_flag <= 1'b0;
          if (op_kind == `KIND_MODIFY) write_latch_flag <= 1'b0;
        end
        // reads end cleanly at any bit select rise resets
        state_r  <= ST_IDLE;
        out_en_r <= 1'b0;
        active_r <= 1'b0;
      end else if (cs_fall) begin
        state_r  <= ST_CMD;
        bit_r    <= {`BIT_CNT_W{1'b0}};
        nbyte_r  <= {`BYTE_CNT_W{1'b0}};
        out_en_r <= 1'b0;
      end else begin
        if (rise && state_r != ST_STBY) begin
          sh_r  <= byte_nxt;
          bit_r <= bit_r + 3'h1;
        end
        if (byte_done) begin
          case (state_r)
            ST_CMD: begin
              op_r    <= byte_nxt;
              nbyte_r <= 3'h1;
              if (kind_of(byte_nxt) == `KIND_NONE) begin
                state_r <= ST_STBY;
              end else begin
                state_r  <= ST_ACT;
                active_r <= 1'b1;
                if (kind_of(byte_nxt) == `KIND_RDSR) begin
                  out_en_r <= 1'b1;
                  out_sh_r <= status_in;
                end
              end
            end
            ST_ACT: begin
              if (nbyte_r <= `ADDR_BYTES) begin
                addr_r <= {addr_r[15:0], byte_nxt};
                nbyte_r <= nbyte_r + 3'h1;
                // array reads are dropped while busy
                if (nbyte_r == `ADDR_BYTES && op_kind == `KIND_READ &&
                    ~busy) begin
                  array_rd_r <= 1'b1;
                  out_en_r   <= 1'b1;
                end
              end else if (op_kind == `KIND_MODIFY && ~push_r) begin
                push_r      <= 1'b1;
                push_data_r <= byte_nxt;
                nbyte_r     <= nbyte_r;
              end
            end
            default: begin
              state_r <= state_r;
            end
          endcase
        end

        // data out on falling edges, msb first
        if (fall && out_en_r) begin
          if (bit_r == {`BIT_CNT_W{1'b0}}) begin
            if (op_kind == `KIND_RDSR) begin
              so       <= status_in[7];
              out_sh_r <= {status_in[6:0], 1'b0};
            end else begin
              so       <= array_rdata[7];
              out_sh_r <= {array_rdata[6:0], 1'b0};
              if (nbyte_r > `ADDR_BYTES) begin
                addr_r <= (addr_r == `ARRAY_TOP) ? {`ADDR_W{1'b0}} :
                          addr_r + 24'h000001;
                // no fetch while the array is busy
                array_rd_r <= ~busy;
              end
            end
          end else begin
            so       <= out_sh_r[7];
            out_sh_r <= {out_sh_r[6:0], 1'b0};
          end
        end
      end
    end
  end

  // floating follows the pin itself, not the pause state
  wire hold_float = pause_en & ~hold;
  // output floats in standby and while paused
  assign so_oe = out_en_r & ~csn & (state_r == ST_ACT) & ~hold_float;

  // the shared pin is only read here, never driven
  assign quad_data_3_o  = 1'b0;
  assign quad_data_3_oe = 1'b0;

  // map the latched address onto sectors and blocks
  always @(posedge mclk) begin
    if (reset) begin
      sector_r     <= {`SECTOR_W{1'b0}};
      half_block_r <= {`HALF_W{1'b0}};
      block_r      <= {`BLOCK_W{1'b0}};
      addr_valid_r <= 1'b0;
    end else begin
      sector_r     <= addr_r[`SECTOR_LSB+`SECTOR_W-1:`SECTOR_LSB];
      half_block_r <= addr_r[`HALF_LSB+`HALF_W-1:`HALF_LSB];
      block_r      <= addr_r[`BLOCK_LSB+`BLOCK_W-1:`BLOCK_LSB];
      addr_valid_r <= (addr_r <= `ARRAY_TOP);
    end
  end

  flash_fe_buf #(
    .WIDTH(8)
  ) u_buf (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (push_r),
    .in_ready  (buf_ready),
    .in_data   (push_data_r),
    .out_valid (data_valid),
    .out_ready (data_ready),
    .out_data  (data_out)
  );
endmodule

//--- flash_fe_checker.sv
// port assertions for the serial flash front end
`timescale 1ns/100ps
`include "flash_fe_defs.vh"
module flash_fe_checker (
  input logic        mclk,
  input logic        reset,
  input logic        cs_n,
  input logic        so_oe,
  input logic        quad_mode,
  input logic        quad_data_3_i,
  input logic        busy,
  input logic [23:0] addr_r,
  input logic        array_rd_r,
  input logic [2:0]  exec_kind_r,
  input logic        exec_r,
  input logic        write_latch_flag,
  input logic [7:0]  sector_r,
  input logic [4:0]  half_block_r,
  input logic [3:0]  block_r,
  input logic        addr_valid_r,
  input logic        active_r,
  input logic        paused_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_idle;
    cs_n [*6];
  endsequence
  sequence s_mod;
    exec_r && exec_kind_r == `KIND_MODIFY;
  endsequence
  property p_standby;
    s_idle |-> !so_oe && !active_r;
  endproperty
  a_standby: assert property (p_standby)
    else $error("output or active while deselected");
  sequence s_hold;
    (!quad_mode && !quad_data_3_i) [*3];
  endsequence
  property p_float;
    s_hold |-> !so_oe;
  endproperty
  a_float: assert property (p_float)
    else $error("output driven while paused");
  property p_quad;
    quad_mode [*4] |-> !paused_r;
  endproperty
  a_quad: assert property (p_quad)
    else $error("paused in four-wire mode");
  property p_unpause;
    s_idle |-> !paused_r;
  endproperty
  a_unpause: assert property (p_unpause)
    else $error("pause kept after deselect");
  property p_exec;
    exec_r |-> cs_n ##1 !exec_r;
  endproperty
  a_exec: assert property (p_exec)
    else $error("execute pulse not at deselect");
  property p_latch;
    s_mod |-> write_latch_flag || $past(write_latch_flag);
  endproperty
  a_latch: assert property (p_latch)
    else $error("modify ran with latch clear");
  property p_busy;
    busy [*4] |-> !array_rd_r && !(exec_r && exec_kind_r == `KIND_MODIFY);
  endproperty
  a_busy: assert property (p_busy)
    else $error("access while busy");
  property p_map;
    addr_valid_r |-> {block_r, half_block_r, sector_r} ==
      {$past(addr_r[19:16]), $past(addr_r[19:15]), $past(addr_r[19:12])};
  endproperty
  a_map: assert property (p_map)
    else $error("address map mismatch");
endmodule

bind flash_fe flash_fe_checker u_flash_fe_checker (.mclk, .reset, .cs_n,
  .so_oe, .quad_mode, .quad_data_3_i, .busy, .addr_r, .array_rd_r,
  .exec_kind_r, .exec_r,
  .write_latch_flag, .sector_r, .half_block_r, .block_r, .addr_valid_r,
  .active_r, .paused_r);

//--- flash_host.sv
// serial controller model for the flash front end
`timescale 1ns/100ps
module flash_host (
  input  logic mclk,
  input  logic so,
  input  logic so_oe,
  output logic cs_n = 1'b1,
  output logic sclk = 1'b0,
  output logic si = 1'b0,
  output logic hold_n = 1'b1
);
  logic cpol = 1'b0;
  task automatic half();
    repeat (8) @(posedge mclk);
  endtask
  task automatic start();
    sclk <= cpol;
    half();
    cs_n <= 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] b, input int nb,
                      output logic [7:0] r);
    for (int i = 0; i < nb; i++) begin
      sclk <= 1'b0;
      si <= b[7-i];
      half();
      r = {r[6:0], so_oe ? so : 1'bz};
      sclk <= 1'b1;
      half();
    end
  endtask
  task automatic stop();
    sclk <= cpol;
    half();
    cs_n <= 1'b1;
    si <= ~si;
    half();
  endtask
  task automatic pause(input logic v);
    sclk <= 1'b0;
    half();
    hold_n <= v;
    half();
  endtask
endmodule

//--- tb_flash_fe.sv
// testbench for the serial flash front end
`timescale 1ns/100ps
`include "flash_fe_defs.vh"
module tb_flash_fe;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        quad_mode = 1'b0;
  logic        busy = 1'b0;
  logic        data_ready = 1'b0;
  logic [7:0]  status_in = 8'h3C;
  logic [7:0]  array_rdata = 8'h00;
  logic [7:0]  rx, last_op;
  logic [23:0] addr_r;
  int          fail_count = 0;
  int          n_compared = 0;
  int          n_exec = 0;
  wire         cs_n, sclk, si, hold_n, so, so_oe, exec_r, data_valid;
  wire         write_latch_flag, active_r, paused_r;
  wire [7:0]   data_out, exec_op_r, sector_r;
  wire [4:0]   half_block_r;
  wire [3:0]   block_r;
  wire [2:0]   exec_kind_r;
  always #5 mclk = ~mclk;
  always @(posedge mclk) array_rdata <= addr_r[7:0] ^ 8'h5A;
  always @(posedge mclk)
    if (exec_r === 1'b1) begin
      n_exec++;
      last_op = exec_op_r;
    end
  flash_host u_flash_host (.mclk, .so, .so_oe, .cs_n, .sclk, .si, .hold_n);
  flash_fe u_flash_fe (.mclk, .reset, .cs_n, .sclk, .si, .so, .so_oe,
    .quad_data_3_i(hold_n), .quad_data_3_o(), .quad_data_3_oe(),
    .quad_mode, .busy, .status_in, .array_rdata, .addr_r, .array_rd_r(),
    .exec_kind_r, .exec_op_r, .exec_r, .write_latch_flag, .sector_r,
    .half_block_r, .block_r, .addr_valid_r(), .data_valid, .data_ready,
    .data_out, .active_r, .paused_r);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                     input int na, input int nd);
    logic [7:0] d;
    d = 8'hC3;
    u_flash_host.start();
    u_flash_host.xfer(op, 8, rx);
    repeat (na) begin
      u_flash_host.xfer(a[23:16], 8, rx);
      a = a << 8;
    end
    repeat (nd) begin
      u_flash_host.xfer(d, 8, rx);
      d = d + 8'h01;
    end
  endtask
  task automatic t_unknown();
    cmd(8'hFF, 24'h0, 0, 0);
    u_flash_host.xfer(8'h00, 8, rx);
    chk({active_r, so_oe}, 2'b00);
    u_flash_host.stop();
    $display("test unknown done");
  endtask
  task automatic t_read();
    for (int m = 0; m < 2; m++) begin
      u_flash_host.cpol = m[0];
      status_in <= m[0] ? 8'hA6 : 8'h3C;
      cmd(8'h05, 24'h0, 0, 0);
      chk(active_r, 1'b1);
      u_flash_host.xfer(8'h00, 8, rx);
      chk(rx, status_in);
      u_flash_host.xfer(8'h00, 3, rx);
      u_flash_host.stop();
      chk(active_r, 1'b0);
      cmd(8'h03, 24'h0FFFFF, 3, 0);
      u_flash_host.xfer(8'h00, 8, rx);
      chk(rx, 8'hA5);
      u_flash_host.xfer(8'h00, 8, rx);
      chk(rx, 8'h5A);
      u_flash_host.stop();
    end
    $display("test read done");
  endtask
  task automatic t_modify();
    int e;
    // status read once and compared with status_in before commanding
    cmd(8'h05, 24'h0, 0, 0);
    u_flash_host.xfer(8'h00, 8, rx);
    u_flash_host.stop();
    chk(rx, status_in);
    cmd(8'h06, 24'h0, 0, 0);
    u_flash_host.stop();
    chk(write_latch_flag, 1'b1);
    chk(exec_kind_r, `KIND_WRITE_ENABLE_CMD);
    e = n_exec;
    busy <= 1'b1;
    cmd(8'h20, 24'h0AB123, 3, 0);
    u_flash_host.stop();
    chk(n_exec, e);
    busy <= 1'b0;
    cmd(8'h20, 24'h0AB123, 3, 0);
    u_flash_host.xfer(8'hFF, 3, rx);
    u_flash_host.stop();
    chk(n_exec, e);
    cmd(8'h20, 24'h0AB123, 3, 0);
    u_flash_host.stop();
    chk(n_exec, e + 1);
    chk(last_op, 8'h20);
    chk(exec_kind_r, `KIND_MODIFY);
    chk({block_r, half_block_r, sector_r}, {4'hA, 5'h15, 8'hAB});
    chk(write_latch_flag, 1'b0);
    cmd(8'h20, 24'h0, 3, 0);
    u_flash_host.stop();
    chk(n_exec, e + 1);
    $display("test modify done");
  endtask
  task automatic t_buffer();
    cmd(8'h06, 24'h0, 0, 0);
    u_flash_host.stop();
    cmd(8'h02, 24'h000100, 3, 2);
    u_flash_host.stop();
    chk(last_op, 8'h02);
    data_ready <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      #1;
      chk(data_valid, k < 2);
      if (k < 2) chk(data_out, 8'hC3 + k);
      @(posedge mclk);
    end
    data_ready <= 1'b0;
    $display("test buffer done");
  endtask
  task automatic t_pause();
    u_flash_host.cpol = 1'b0;
    u_flash_host.start();
    u_flash_host.xfer(8'h05, 4, rx);
    u_flash_host.hold_n <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(paused_r, 1'b0);
    u_flash_host.pause(1'b0);
    chk({paused_r, so_oe}, 2'b10);
    u_flash_host.xfer(8'hFF, 3, rx);
    u_flash_host.pause(1'b1);
    chk(paused_r, 1'b0);
    u_flash_host.xfer(8'h50, 4, rx);
    u_flash_host.xfer(8'h00, 8, rx);
    chk(rx, status_in);
    u_flash_host.stop();
    u_flash_host.start();
    u_flash_host.xfer(8'h05, 8, rx);
    u_flash_host.pause(1'b0);
    chk({paused_r, active_r}, 2'b11);
    u_flash_host.stop();
    chk({paused_r, active_r}, 2'b00);
    u_flash_host.pause(1'b1);
    quad_mode <= 1'b1;
    u_flash_host.start();
    u_flash_host.xfer(8'h05, 4, rx);
    u_flash_host.pause(1'b0);
    chk(paused_r, 1'b0);
    u_flash_host.pause(1'b1);
    u_flash_host.stop();
    quad_mode <= 1'b0;
    $display("test pause done");
  endtask
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    t_unknown();
    t_read();
    t_modify();
    t_buffer();
    t_pause();
    test_done();
  end
  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    test_done();
  end
endmodule
